// ==== rtl/i2cm_pkg.sv ====
// Purpose: shared constants and types of the i2c control/status block
// Assumes: 20 MHz ref_clk, registers on a 32-bit APB slave port
// Notes: register byte addresses are one aligned word each
`default_nettype none
package i2cm_pkg;
  // timing of the generated bus clock: half period of a 100 kHz scl
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                SCL_HALF_NS / CLK_PERIOD_NS;
  localparam logic [6:0] SCL_HALF_CNT = 7'(SCL_HALF_CYC - 1);
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SR1 = 8'h04;
  localparam logic [7:0] ADDR_SR2 = 8'h08;
  localparam logic [7:0] ADDR_OWN = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  // control_word fields
  localparam int CR_PE = 5;
  localparam int CR_GC = 4;
  localparam int CR_START = 3;
  localparam int CR_ACK = 2;
  localparam int CR_STOP = 1;
  localparam int CR_ITE = 0;
  // first_status fields
  localparam int S1_EVF = 7;
  localparam int S1_HDR = 6;
  localparam int S1_TRA = 5;
  localparam int S1_BUSY = 4;
  localparam int S1_BTF = 3;
  localparam int S1_OWN_MATCH_FLAG = 2;
  localparam int S1_LEAD = 1;
  localparam int S1_SB = 0;
  // second_status fields
  localparam int S2_AF = 4;
  localparam int S2_HALT_CONDITION_SEEN = 3;
  localparam int S2_LOST_CONTENTION_FLAG = 2;
  localparam int S2_MISPLACED_CONDITION_FLAG = 1;
  localparam int S2_BROADCAST_SEEN_FLAG = 0;
  // address values and bit slot numbers on the bus
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_IGNORE = 8'h01;
  localparam logic [4:0] HDR_PREFIX = 5'h1E;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  // master condition generator
  typedef enum logic [2:0] {M_IDLE, M_STA, M_RUN, M_REP, M_REP2, M_STO1, M_STO2} i2cm_mst_e;
  // state cleared while the interface is switched off
  typedef struct packed {
    logic pe, gcEn, startReq, ackEn, irqAllow;
    logic hdrSent, sent_not_received_flag, busy, byte_done_flag, own_match_flag, master, sb;
    logic af, halt_condition_seen, lost_contention_flag, misplaced_condition_flag, broadcast_seen_flag, ev6;
    logic inAddr, xmit, slvSel, txReady, nack, hdrPhase;
    logic sdaLow, mSclLow, mSdaLow;
    logic [3:0] bitCnt;
    i2cm_mst_e mState;
  } i2cm_st_s;
  // state kept while the interface is switched off
  typedef struct packed {
    logic sclS1, sclS2, sclPrev, sdaS1, sdaS2, sdaPrev;
    logic stopReq, rdSr1, rdSr2;
    logic [7:0] ownAddr, dataReg, shiftReg, rdData;
    logic [6:0] halfCnt;
  } i2cm_keep_s;
  localparam i2cm_st_s ST_RESET = '0;
  localparam i2cm_keep_s KEEP_RESET = '0;
endpackage
`default_nettype wire

// ==== rtl/i2cm_ctrl.sv ====
// Purpose: multimaster/slave i2c control word, status words and bus engine
// Assumes: open-drain pins, ref_clk 20 MHz, apb slave with zero wait states
// Notes: clock divider and 10-bit own address are not modelled
//
// Notes on behaviour
// - switched off: clear control and status except stop request, release pins
// - first enabling write sets only enable; second write loads the rest
// - broadcast accept: ack 00h, ignore 01h, flag it, receive only
// - start request: repeated start as master, start on free bus as slave
// - ack enable returns ack after received address or data bytes
// - master stop after byte or pending start; hardware clears; off keeps it
// - slave stop request releases both lines after the byte; software clears
// - irq allow gates the single interrupt; cleared when switched off
// - hold scl low while header, start, byte done, match or address event
// - summary flag is the or of all event flags and the address event
// - header flag set after 10-bit header; second status read then data write
// - direction flag valid with byte done; cleared by stop, loss, off
// - busy set on start, cleared on stop or bus error
// - byte done after ack clock; cleared by first status read then data access
// - match flag on own or broadcast address; cleared by first status read
// - leader flag set when start makes us master; cleared on stop, loss, off
// - start-sent flag set after start; cleared by first status read, data write
// - nack flag set on missing ack, cleared by second status read, no stretch
// - slave stop flag set on stop after ack, cleared by second status read
// - arbitration loss: flag, back to slave, no stretch, none during ack bit
// - misplaced start or stop sets bus error; second status read clears it
`default_nettype none
module i2cm_ctrl
  import i2cm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // open-drain bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // interrupt request to the cpu
  output logic irqReq
);

  i2cm_st_s st_reg, st_next;
  i2cm_keep_s kp_reg, kp_next;
  logic acc, regWr, regRd, mapped;
  logic sclRise, sclFall, startSeen, stopSeen, byteEndEv;
  logic txing, stretch, any_event_flag, slaveHold, tick, arbLoss;

  // own or broadcast address seen on the bus; 01h is never answered
  function automatic logic addrHit(input logic [7:0] b, input logic [7:0] own,
                                   input logic gc);
    return (b != GC_IGNORE) && ((b[7:1] == own[7:1]) || (gc && b == GC_ADDR));
  endfunction

  // bus access decode, zero wait states
  assign acc = psel & penable;
  assign regWr = acc & pwrite;
  assign regRd = acc & ~pwrite;
  assign mapped = paddr inside {ADDR_CTRL, ADDR_SR1, ADDR_SR2, ADDR_OWN, ADDR_DATA};
  assign pready = 1'h1;
  assign pslverr = acc & ~mapped;
  assign prdata = {24'h00_0000, kp_reg.rdData};

  // line events, seen only on the second synchroniser stage and after
  assign sclRise = kp_reg.sclS2 & ~kp_reg.sclPrev;
  assign sclFall = ~kp_reg.sclS2 & kp_reg.sclPrev;
  assign startSeen = kp_reg.sclS2 & kp_reg.sclPrev & kp_reg.sdaPrev & ~kp_reg.sdaS2;
  assign stopSeen = kp_reg.sclS2 & kp_reg.sclPrev & ~kp_reg.sdaPrev & kp_reg.sdaS2;
  assign byteEndEv = st_reg.pe & sclFall & ~startSeen & ~stopSeen & (st_reg.bitCnt == BIT_END);
  assign tick = kp_reg.halfCnt == SCL_HALF_CNT;

  // role decode and the summary event flag
  assign txing = st_reg.master ? (st_reg.inAddr | st_reg.xmit) :
                 (st_reg.slvSel & st_reg.xmit & ~st_reg.inAddr);
  assign stretch = st_reg.hdrSent | st_reg.sb | st_reg.byte_done_flag | st_reg.own_match_flag | st_reg.ev6;
  assign any_event_flag = stretch | st_reg.af | st_reg.halt_condition_seen | st_reg.lost_contention_flag | st_reg.misplaced_condition_flag;
  assign arbLoss = st_reg.pe & sclRise & ~startSeen & st_reg.master & txing &
                   (st_reg.bitCnt < BIT_ACK) & ~st_reg.sdaLow & ~kp_reg.sdaS2;
  // a slave holds scl only between bytes, and lets go when asked to stop
  assign slaveHold = st_reg.slvSel & ~st_reg.master & stretch & (st_reg.bitCnt == 4'h0) &
                     ~kp_reg.stopReq;

  // pins: never drive high, enables pull the wire low
  assign sclOut = 1'h0;
  assign sdaOut = 1'h0;
  assign sclOe = st_reg.pe & (st_reg.mSclLow | slaveHold);
  assign sdaOe = st_reg.pe & (st_reg.mSdaLow | st_reg.sdaLow);
  assign irqReq = st_reg.irqAllow & any_event_flag;

  // next state: bus effects first, then line events, so a set beats a clear
  always_comb begin
    logic [3:0] nb;
    logic isGc;
    nb = 4'h0;
    isGc = 1'h0;
    st_next = st_reg;
    kp_next = kp_reg;
    kp_next.sclS1 = sclIn;
    kp_next.sclS2 = kp_reg.sclS1;
    kp_next.sclPrev = kp_reg.sclS2;
    kp_next.sdaS1 = sdaIn;
    kp_next.sdaS2 = kp_reg.sdaS1;
    kp_next.sdaPrev = kp_reg.sdaS2;
    kp_next.halfCnt = tick ? 7'h00 : 7'(kp_reg.halfCnt + 7'h01);

    // read data is latched in the setup cycle; side effects wait for the access
    if (psel & ~penable) begin
      kp_next.rdData = 8'h00;
      case (paddr)
        ADDR_CTRL: begin
          kp_next.rdData[CR_PE] = st_reg.pe;
          kp_next.rdData[CR_GC] = st_reg.gcEn;
          kp_next.rdData[CR_START] = st_reg.startReq;
          kp_next.rdData[CR_ACK] = st_reg.ackEn;
          kp_next.rdData[CR_STOP] = kp_reg.stopReq;
          kp_next.rdData[CR_ITE] = st_reg.irqAllow;
        end
        ADDR_SR1: begin
          kp_next.rdData[S1_EVF] = any_event_flag;
          kp_next.rdData[S1_HDR] = st_reg.hdrSent;
          kp_next.rdData[S1_TRA] = st_reg.sent_not_received_flag;
          kp_next.rdData[S1_BUSY] = st_reg.busy;
          kp_next.rdData[S1_BTF] = st_reg.byte_done_flag;
          kp_next.rdData[S1_OWN_MATCH_FLAG] = st_reg.own_match_flag;
          kp_next.rdData[S1_LEAD] = st_reg.master;
          kp_next.rdData[S1_SB] = st_reg.sb;
        end
        ADDR_SR2: begin
          kp_next.rdData[S2_AF] = st_reg.af;
          kp_next.rdData[S2_HALT_CONDITION_SEEN] = st_reg.halt_condition_seen;
          kp_next.rdData[S2_LOST_CONTENTION_FLAG] = st_reg.lost_contention_flag;
          kp_next.rdData[S2_MISPLACED_CONDITION_FLAG] = st_reg.misplaced_condition_flag;
          kp_next.rdData[S2_BROADCAST_SEEN_FLAG] = st_reg.broadcast_seen_flag;
        end
        ADDR_OWN: kp_next.rdData = kp_reg.ownAddr;
        ADDR_DATA: kp_next.rdData = kp_reg.dataReg;
        default: kp_next.rdData = 8'h00;
      endcase
    end

    // clear sequences remember only the access just before
    if (acc) begin
      kp_next.rdSr1 = 1'h0;
      kp_next.rdSr2 = 1'h0;
    end
    if (regRd && paddr == ADDR_SR1) begin
      kp_next.rdSr1 = 1'h1;
      st_next.own_match_flag = 1'h0;
      if (st_reg.own_match_flag && st_reg.xmit) begin
        st_next.byte_done_flag = 1'h1; // slave transmitter now waits for its first byte
        st_next.sent_not_received_flag = 1'h1;
      end
    end
    if (regRd && paddr == ADDR_SR2) begin
      kp_next.rdSr2 = 1'h1;
      st_next.af = 1'h0;
      st_next.halt_condition_seen = 1'h0;
      st_next.lost_contention_flag = 1'h0;
      st_next.misplaced_condition_flag = 1'h0;
    end
    if (acc && paddr == ADDR_DATA) begin
      if (kp_reg.rdSr1) begin
        st_next.byte_done_flag = 1'h0;
      end
      if (pwrite) begin
        kp_next.dataReg = pwdata[7:0];
        if (kp_reg.rdSr1) begin
          st_next.sb = 1'h0;
        end
        if (kp_reg.rdSr2) begin
          st_next.hdrSent = 1'h0;
        end
        if (txing && st_reg.bitCnt == 4'h0) begin
          kp_next.shiftReg = pwdata[7:0];
          st_next.txReady = 1'h1;
          st_next.sdaLow = ~pwdata[7]; // first bit goes out while scl is low
        end
      end
    end
    if (regWr && paddr == ADDR_OWN) begin
      kp_next.ownAddr = pwdata[7:0];
    end
    if (regWr && paddr == ADDR_CTRL) begin
      if (!st_reg.pe) begin
        st_next.pe = pwdata[CR_PE];
      end else begin
        st_next.pe = pwdata[CR_PE];
        st_next.gcEn = pwdata[CR_GC];
        st_next.startReq = pwdata[CR_START];
        st_next.ackEn = pwdata[CR_ACK];
        kp_next.stopReq = pwdata[CR_STOP];
        st_next.irqAllow = pwdata[CR_ITE];
        if (kp_reg.rdSr1 && st_reg.ev6) begin
          st_next.ev6 = 1'h0;
          if (st_reg.master && st_reg.xmit) begin
            st_next.byte_done_flag = 1'h1;
            st_next.sent_not_received_flag = 1'h1;
          end
        end
      end
    end

    // master condition generator, paced by the half-period tick
    if (st_reg.pe) begin
      case (st_reg.mState)
        M_IDLE: begin
          if (st_reg.startReq && !st_reg.master && !st_reg.busy && kp_reg.sclS2 &&
              kp_reg.sdaS2) begin
            st_next.mSdaLow = 1'h1;
            st_next.mState = M_STA;
          end
        end
        M_STA: begin
          if (tick) begin
            st_next.mSclLow = 1'h1;
            st_next.master = 1'h1;
            st_next.sb = 1'h1;
            st_next.startReq = 1'h0;
            st_next.mState = M_RUN;
          end
        end
        M_RUN: begin
          if (st_reg.bitCnt == 4'h0 && st_reg.mSclLow) begin
            if (kp_reg.stopReq) begin
              st_next.sdaLow = 1'h0;
              st_next.mSdaLow = 1'h1;
              st_next.mState = M_STO1;
            end else if (st_reg.startReq) begin
              st_next.sdaLow = 1'h0;
              st_next.mSdaLow = 1'h0;
              st_next.mState = M_REP;
            end else if (tick && !stretch && !(txing && !st_reg.txReady)) begin
              st_next.mSclLow = 1'h0;
              st_next.mSdaLow = 1'h0;
            end
          end else if (tick) begin
            st_next.mSdaLow = 1'h0;
            if (st_reg.mSclLow) begin
              st_next.mSclLow = 1'h0;
            end else if (kp_reg.sclS2) begin
              st_next.mSclLow = 1'h1; // low phase starts once the line is seen high
            end
          end
        end
        M_STO1: begin
          if (tick) begin
            st_next.mSclLow = 1'h0;
            st_next.mState = M_STO2;
          end
        end
        M_STO2: begin
          if (tick && kp_reg.sclS2) begin
            st_next.mSdaLow = 1'h0;
            kp_next.stopReq = 1'h0;
            st_next.mState = M_IDLE;
          end
        end
        M_REP: begin
          if (tick) begin
            st_next.mSclLow = 1'h0;
            st_next.mState = M_REP2;
          end
        end
        M_REP2: begin
          if (tick && kp_reg.sclS2) begin
            st_next.mSdaLow = 1'h1;
            st_next.mState = M_STA;
          end
        end
        default: st_next.mState = M_IDLE;
      endcase
    end

    // bit engine driven by the observed scl and sda
    // the first scl rise of a slot may belong to a stop or repeated start, so a
    // condition there is never counted as misplaced
    if (st_reg.pe && startSeen) begin
      st_next.busy = 1'h1;
      if (st_reg.bitCnt > 4'h1 && (st_reg.slvSel || st_reg.master)) begin
        st_next.misplaced_condition_flag = 1'h1;
        st_next.busy = 1'h0;
      end
      st_next.bitCnt = 4'h0;
      st_next.inAddr = 1'h1;
      st_next.slvSel = 1'h0;
    end else if (st_reg.pe && stopSeen) begin
      st_next.busy = 1'h0;
      if (st_reg.bitCnt > 4'h1 && (st_reg.slvSel || st_reg.master)) begin
        st_next.misplaced_condition_flag = 1'h1;
      end else if (st_reg.slvSel && !st_reg.master && st_reg.ackEn) begin
        st_next.halt_condition_seen = 1'h1;
      end
      st_next.master = 1'h0;
      st_next.sent_not_received_flag = 1'h0;
      st_next.broadcast_seen_flag = 1'h0;
      st_next.slvSel = 1'h0;
      st_next.inAddr = 1'h0;
      st_next.bitCnt = 4'h0;
      st_next.sdaLow = 1'h0;
      st_next.mSclLow = 1'h0;
      st_next.mSdaLow = 1'h0;
      st_next.mState = M_IDLE;
    end else if (st_reg.pe && sclRise) begin
      if (st_reg.bitCnt < BIT_ACK) begin
        kp_next.shiftReg = {kp_reg.shiftReg[6:0], kp_reg.sdaS2};
      end
      if (st_reg.bitCnt == BIT_ACK) begin
        st_next.nack = kp_reg.sdaS2;
      end
      if (st_reg.bitCnt < BIT_END) begin
        st_next.bitCnt = 4'(st_reg.bitCnt + 4'h1);
      end
      if (arbLoss) begin
        st_next.lost_contention_flag = 1'h1;
        st_next.master = 1'h0;
        st_next.sent_not_received_flag = 1'h0;
        st_next.mState = M_IDLE;
        st_next.mSclLow = 1'h0;
        st_next.sdaLow = 1'h0;
      end
    end else if (st_reg.pe && sclFall) begin
      nb = (st_reg.bitCnt == BIT_END) ? 4'h0 : st_reg.bitCnt;
      st_next.bitCnt = nb;
      isGc = st_reg.gcEn && kp_reg.shiftReg == GC_ADDR;
      if (byteEndEv) begin
        st_next.sdaLow = 1'h0;
        st_next.inAddr = 1'h0;
        if (st_reg.inAddr && st_reg.master) begin
          st_next.txReady = 1'h0;
          if (st_reg.nack) begin
            st_next.af = 1'h1;
          end else if (kp_reg.dataReg[7:3] == HDR_PREFIX && !kp_reg.dataReg[0] &&
                       !st_reg.hdrPhase) begin
            st_next.hdrSent = 1'h1;
            st_next.hdrPhase = 1'h1;
            st_next.inAddr = 1'h1;
          end else begin
            st_next.ev6 = 1'h1;
            st_next.hdrPhase = 1'h0;
            st_next.xmit = st_reg.hdrPhase | ~kp_reg.dataReg[0];
          end
        end else if (st_reg.inAddr) begin
          if (st_reg.ackEn && addrHit(kp_reg.shiftReg, kp_reg.ownAddr, st_reg.gcEn)) begin
            st_next.own_match_flag = 1'h1;
            st_next.slvSel = 1'h1;
            st_next.broadcast_seen_flag = isGc;
            st_next.xmit = kp_reg.shiftReg[0] & ~isGc;
          end
        end else if (st_reg.master || st_reg.slvSel) begin
          if (txing) begin
            st_next.byte_done_flag = 1'h1;
            st_next.sent_not_received_flag = 1'h1;
            st_next.txReady = 1'h0;
            if (st_reg.nack) begin
              st_next.af = 1'h1;
            end
          end else begin
            kp_next.dataReg = kp_reg.shiftReg;
            if (st_reg.ackEn) begin
              st_next.byte_done_flag = 1'h1;
              st_next.sent_not_received_flag = 1'h0;
            end
          end
        end
      end else if (nb == BIT_ACK) begin
        // receivers answer in the ninth clock
        st_next.sdaLow = st_reg.ackEn & (st_reg.inAddr ?
          (~st_reg.master & addrHit(kp_reg.shiftReg, kp_reg.ownAddr, st_reg.gcEn)) :
          (~txing & (st_reg.master | st_reg.slvSel)));
      end else if (nb != 4'h0) begin
        st_next.sdaLow = txing & ~kp_reg.shiftReg[7];
      end
      if (!st_reg.master && kp_reg.stopReq && byteEndEv) begin
        st_next.sdaLow = 1'h0;
      end
    end

    // direction only means something beside byte done
    if (!st_next.byte_done_flag) begin
      st_next.sent_not_received_flag = 1'h0;
    end
    // switched off: everything in i2cm_st_s clears; the stop request, stored bytes, synchronisers, tick counter and read memories stay
    if (!st_next.pe) begin
      st_next = ST_RESET;
    end
  end

  // register both state groups
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= ST_RESET;
      kp_reg <= KEEP_RESET;
    end else begin
      st_reg <= st_next;
      kp_reg <= kp_next;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence sr1RdSeq;
    regRd && paddr == ADDR_SR1;
  endsequence
  sequence drWrSeq;
    regWr && paddr == ADDR_DATA && !byteEndEv;
  endsequence

  off_release_a: assert property (!st_reg.pe |-> !sclOe && !sdaOe && !any_event_flag)
    else $error("pins or flags active while switched off");
  first_write_a: assert property ((regWr && paddr == ADDR_CTRL && !st_reg.pe) |=>
    st_reg.pe == $past(pwdata[CR_PE]) && !st_reg.ackEn && !st_reg.irqAllow)
    else $error("first enabling write loaded more than enable");
  stop_kept_a: assert property ((!st_reg.pe && !(regWr && paddr == ADDR_CTRL)) |=>
    $stable(kp_reg.stopReq))
    else $error("stop request changed while switched off");
  irq_gate_a: assert property (irqReq |-> st_reg.irqAllow && any_event_flag)
    else $error("interrupt without enable or event");
  master_hold_a: assert property ((st_reg.mState == M_RUN && st_reg.byte_done_flag && st_reg.mSclLow &&
    st_reg.bitCnt == 4'h0 && !kp_reg.stopReq && !st_reg.startReq && !stopSeen &&
    !startSeen) |=> sclOe)
    else $error("scl released while byte done stands");
  busy_stop_a: assert property ((st_reg.pe && stopSeen) |=>
    !st_reg.busy && !st_reg.master)
    else $error("busy or leader still set after stop");
  sb_clear_a: assert property (sr1RdSeq ##[2:3] drWrSeq |=> !st_reg.sb)
    else $error("start-sent flag survived its clear sequence");
  btf_clear_a: assert property ((sr1RdSeq ##[2:3] (acc && paddr == ADDR_DATA && !byteEndEv))
    |=> !st_reg.byte_done_flag && !st_reg.sent_not_received_flag)
    else $error("byte done survived its clear sequence");
  own_match_flag_clear_a: assert property ((sr1RdSeq and !byteEndEv) |=> !st_reg.own_match_flag)
    else $error("match flag survived a first status read");
  arb_loss_a: assert property (arbLoss |=> st_reg.lost_contention_flag && !st_reg.master && !sclOe)
    else $error("arbitration loss not handled");

endmodule // i2cm_ctrl
`default_nettype wire

// ==== testbench/i2cm_bus_peer.sv ====
// Purpose: behavioural peer master on the shared i2c wires
// Assumes: pulled-up open-drain wires, 400 ns link clock period
// Notes: scl stands still between frames; stretch waits are bounded
`default_nettype none
module i2cm_bus_peer (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // pull-downs onto the wires
  output logic sclLow,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ns;
  // both lines released until a frame starts
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // release scl and honour a stretch, giving up after 200 us
  task automatic sclUp();
    int n;
    n = 0;
    sclLow = 1'b0;
    while (scl !== 1'b1 && n < 2000) begin
      #100;
      n++;
    end
    #100;
  endtask
  // the 13 ns offset keeps every wire change off the ref_clk edges
  task automatic startCond();
    #13 sdaLow = 1'b0;
    sclUp();
    sdaLow = 1'b1;
    #200 sclLow = 1'b1;
  endtask
  // eight bits msb first, then the ninth slot left to the receiver
  task automatic sendByte(input logic [7:0] b, output logic nack);
    #13;
    for (int i = 7; i >= -1; i--) begin
      #100 sdaLow = (i >= 0) ? !b[i] : 1'b0;
      #100 sclUp();
      if (i < 0) nack = sda;
      #100 sclLow = 1'b1;
    end
    // keep scl low long enough for the block to see the last falling edge
    #200;
  endtask
  // sda rises while scl is high
  task automatic stopCond();
    #113 sdaLow = 1'b1;
    #100 sclUp();
    sdaLow = 1'b0;
    // bus free time; the block needs a few cycles to register the stop
    #300;
  endtask
endmodule // i2cm_bus_peer
`default_nettype wire

// ==== testbench/tb_i2c_master_slave_control_status.sv ====
// Purpose: register and wire level regression of the i2c control block
// Assumes: zero wait state apb, peer master model on the wires
// Notes: expected flag words and masks are hex literals; register addresses come from the package
`default_nettype none
module tb_i2c_master_slave_control_status import i2cm_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, sclOe, sdaOe, irqReq, peerScl, peerSda, ack;
  wire logic scl, sda;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  // open-drain wires with pull-ups
  assign scl = !(sclOe || peerScl);
  assign sda = !(sdaOe || peerSda);
  always #25 ref_clk = ~ref_clk;
  i2cm_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(),
    .sdaOe(sdaOe), .irqReq(irqReq));
  i2cm_bus_peer peer (.scl(scl), .sda(sda), .sclLow(peerScl), .sdaLow(peerSda));
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  // one apb transfer launched at a rising edge; the request stands until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    ack = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(n, rdv[7:0] & m, e);
  endtask
  // pin drives {sclOe, sdaOe, irqReq} once the synchronisers settle
  task automatic pins(input logic [2:0] e);
    repeat (8) @(negedge ref_clk);
    check("pins", {5'h00, sclOe, sdaOe, irqReq}, {5'h00, e});
    @(posedge ref_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdChk("ctrl reset", ADDR_CTRL, 8'hFF, 8'h00);
    rdChk("sr1 reset", ADDR_SR1, 8'hFF, 8'h00);
    rdChk("sr2 reset", ADDR_SR2, 8'hFF, 8'h00);
    xfer(1'b0, 8'h40, 8'h00);
    check("unmapped", {7'h00, ack}, 8'h01);
    wr_en: begin
      xfer(1'b1, ADDR_CTRL, 8'h25);
      rdChk("enable 1", ADDR_CTRL, 8'hFF, 8'h20);
      xfer(1'b1, ADDR_CTRL, 8'h25);
      rdChk("enable 2", ADDR_CTRL, 8'hFF, 8'h25);
    end
    $display("test enable done");
    xfer(1'b1, ADDR_OWN, 8'hA0);
    peer.startCond();
    peer.sendByte(8'hA0, ack);
    check("addr ack", {7'h00, ack}, 8'h00);
    pins(3'b101);
    rdChk("match", ADDR_SR1, 8'hFF, 8'h94);
    rdChk("match clr", ADDR_SR1, 8'h04, 8'h00);
    peer.sendByte(8'h5A, ack);
    check("data ack", {7'h00, ack}, 8'h00);
    pins(3'b101);
    rdChk("byte done", ADDR_SR1, 8'hFF, 8'h98);
    rdChk("rx byte", ADDR_DATA, 8'hFF, 8'h5A);
    rdChk("done clr", ADDR_SR1, 8'h28, 8'h00);
    pins(3'b000);
    peer.stopCond();
    rdChk("stop seen", ADDR_SR2, 8'hFF, 8'h08);
    rdChk("idle", ADDR_SR1, 8'hFF, 8'h00);
    rdChk("stop clr", ADDR_SR2, 8'hFF, 8'h00);
    $display("test slave receive done");
    xfer(1'b1, ADDR_CTRL, 8'h21);
    peer.startCond();
    peer.sendByte(8'hA0, ack);
    check("no ack", {7'h00, ack}, 8'h01);
    rdChk("no match", ADDR_SR1, 8'h04, 8'h00);
    peer.stopCond();
    xfer(1'b1, ADDR_CTRL, 8'h35);
    peer.startCond();
    peer.sendByte(GC_IGNORE, ack);
    check("01h ignored", {7'h00, ack}, 8'h01);
    peer.stopCond();
    peer.startCond();
    peer.sendByte(GC_ADDR, ack);
    check("00h ack", {7'h00, ack}, 8'h00);
    rdChk("gc flag", ADDR_SR2, 8'h01, 8'h01);
    rdChk("gc match", ADDR_SR1, 8'h04, 8'h04);
    peer.stopCond();
    rdChk("gc clr", ADDR_SR2, 8'h01, 8'h00);
    $display("test broadcast done");
    // start on a free bus turns the block into the leader
    xfer(1'b1, ADDR_CTRL, 8'h2C);
    for (int i = 0; i < 400 && sclOe !== 1'b1; i++) @(posedge ref_clk);
    rdChk("start made", ADDR_SR1, 8'h93, 8'h93);
    rdChk("start clr", ADDR_CTRL, 8'h08, 8'h00);
    pins(3'b110);
    xfer(1'b1, ADDR_CTRL, 8'h02);
    rdChk("off ctrl", ADDR_CTRL, 8'hFF, 8'h02);
    rdChk("off sr1", ADDR_SR1, 8'hFF, 8'h00);
    pins(3'b000);
    xfer(1'b1, ADDR_CTRL, 8'h00);
    $display("test master start done");
    summarize();
  end
endmodule // tb_i2c_master_slave_control_status
`default_nettype wire
